// File: bench/alarm_periodic_powerfail_irq_bench.sv
// Self-checking bench for the alarm, periodic and power-fail interrupt block.
`timescale 1ns/10ps
module alarm_periodic_powerfail_irq_bench;
  import irq_pkg::*;
  logic core_clk_i, reset_i = 1'b1, fail_req = 1'b0, power_fail_input_n_i;
  logic [NUM_CMP*BYTE_W-1:0] clock_counters_i = 48'h777777777700;
  logic [NUM_PER-1:0] periodic_ticks_i = '0, periodic_en_i = '0, periodic_flags_o;
  // All bytes enabled from the start so that no match is seen at reset release.
  logic [NUM_CMP-1:0] alarm_cmp_en_i = 6'h3F;
  logic alarm_int_en_i = 1'b0, periodic_route_i = 1'b0, power_fail_int_en_i = 1'b0;
  logic power_fail_route_i = 1'b0, delay_en_i = 1'b0, timer_pf_run_i = 1'b1;
  logic int_pf_run_i = 1'b1, chip_select_i = 1'b0, read_strobe_i = 1'b0;
  logic write_strobe_i = 1'b0, status_wr_i = 1'b0, periodic_access_i = 1'b0, cmp_wr_i = 1'b0;
  logic [STAT_W-1:0] status_wr_data_i = '0, main_status_o;
  logic [CMP_AW-1:0] cmp_addr_i = '0;
  logic [BYTE_W-1:0] cmp_wr_data_i = '0, cmp_rd_data_o;
  logic interrupt_output_o, multi_function_output_o, bus_locked_o;
  logic timers_enabled_o, power_failing_o;
  int bad_count = 0;
  int tests_run = 0;
  int n;

  supply_monitor_model u_supply (.core_clk_i, .fail_req_i(fail_req),
    .power_fail_input_n_o(power_fail_input_n_i));
  alarm_periodic_powerfail_irq u_dut (.core_clk_i, .reset_i, .power_fail_input_n_i,
    .clock_counters_i, .periodic_ticks_i, .alarm_cmp_en_i, .alarm_int_en_i, .periodic_en_i,
    .periodic_route_i, .power_fail_int_en_i, .power_fail_route_i, .delay_en_i,
    .timer_pf_run_i, .int_pf_run_i, .chip_select_i, .read_strobe_i, .write_strobe_i,
    .status_wr_i, .status_wr_data_i, .periodic_access_i, .cmp_wr_i, .cmp_addr_i,
    .cmp_wr_data_i, .cmp_rd_data_o, .main_status_o, .periodic_flags_o, .interrupt_output_o,
    .multi_function_output_o, .bus_locked_o, .timers_enabled_o, .power_failing_o);

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic settle(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int got, input int lo, input int hi, input string what);
    tests_run++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask : chk_in

  task automatic wr_status(input logic [7:0] d);
    @(posedge core_clk_i);
    status_wr_i <= 1'b1;
    status_wr_data_i <= d;
    @(posedge core_clk_i);
    status_wr_i <= 1'b0;
  endtask : wr_status

  task automatic wr_cmp(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    cmp_wr_i <= 1'b1;
    cmp_addr_i <= a;
    cmp_wr_data_i <= d;
    @(posedge core_clk_i);
    cmp_wr_i <= 1'b0;
  endtask : wr_cmp

  task automatic rd_cmp(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    cmp_addr_i <= a;
    settle(2);
    chk({8'h00, cmp_rd_data_o}, {8'h00, exp}, "compare byte read");
  endtask : rd_cmp

  task automatic tick(input logic [5:0] m);
    @(posedge core_clk_i);
    periodic_ticks_i <= m;
    @(posedge core_clk_i);
    periodic_ticks_i <= '0;
  endtask : tick

  task automatic touch_periodic();
    @(posedge core_clk_i);
    periodic_access_i <= 1'b1;
    @(posedge core_clk_i);
    periodic_access_i <= 1'b0;
  endtask : touch_periodic

  // Waits on failing (sel 0) or locked (sel 1); a wait that runs out ends the run.
  task automatic wait_sig(input int sel, input logic val, output int cnt);
    cnt = 0;
    while (((sel == 0) ? power_failing_o : bus_locked_o) !== val && cnt < 12000) begin
      settle(1);
      cnt++;
    end
    if (cnt >= 12000) begin
      bad_count++;
      $display("mismatch at %0t: wait ran out", $time);
      conclude();
    end
  endtask : wait_sig

  task automatic set_fail(input logic f);
    @(posedge core_clk_i);
    fail_req <= f;
  endtask : set_fail

  task automatic conclude();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    settle(4);
    chk({main_status_o, periodic_flags_o, interrupt_output_o, bus_locked_o}, 16'h0000, "reset");
    @(posedge core_clk_i);
    alarm_cmp_en_i <= 6'h03;
    alarm_int_en_i <= 1'b1;
    clock_counters_i <= 48'h777777777700;
    wr_cmp(3'h0, 8'h15);
    wr_cmp(3'h1, 8'h03);
    wr_cmp(3'h5, 8'hA5);
    @(posedge core_clk_i);
    clock_counters_i <= 48'h777777777715;
    settle(3);
    chk({15'h0, main_status_o[ST_ALM_BIT]}, 16'h0000, "partial match");
    @(posedge core_clk_i);
    clock_counters_i <= 48'h777777770315;
    settle(3);
    chk({main_status_o[ST_ALM_BIT], interrupt_output_o, main_status_o[ST_INT_BIT]},
        3'b111, "alarm raised");
    rd_cmp(3'h5, 8'hA5);
    wr_status(8'h08);
    settle(3);
    chk({main_status_o[ST_ALM_BIT], interrupt_output_o, main_status_o[ST_INT_BIT]},
        3'b000, "alarm cleared");
    @(posedge core_clk_i);
    alarm_int_en_i <= 1'b0;
    clock_counters_i <= 48'h777777770316;
    @(posedge core_clk_i);
    clock_counters_i <= 48'h777777770315;
    settle(3);
    chk({main_status_o[ST_ALM_BIT], interrupt_output_o}, 2'b10, "alarm masked");
    wr_status(8'h08);
    tick(6'h01);
    settle(2);
    chk({periodic_flags_o, main_status_o[ST_PER_BIT]}, 7'h02, "tick without enable");
    touch_periodic();
    settle(2);
    chk({10'h0, periodic_flags_o}, 16'h0000, "flags after access");
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk_i);
      periodic_route_i <= r[0];
      periodic_en_i <= 6'h02;
      tick(6'h02);
      settle(3);
      chk({main_status_o[ST_PER_BIT], multi_function_output_o, interrupt_output_o,
           main_status_o[ST_INT_BIT]}, {1'b1, r[0], ~r[0], 1'b1}, "periodic raised");
      @(posedge core_clk_i);
      periodic_en_i <= '0;
      settle(3);
      chk({main_status_o[ST_PER_BIT], multi_function_output_o | interrupt_output_o}, 2'b11,
          "periodic pending");
      wr_status(8'h04);
      settle(3);
      chk({main_status_o[ST_PER_BIT], multi_function_output_o, interrupt_output_o}, 3'b000,
          "periodic cleared");
    end
    set_fail(1'b1);
    repeat (200) @(posedge core_clk_i);
    set_fail(1'b0);
    settle(100);
    chk({15'h0, power_failing_o}, 16'h0000, "short glitch rejected");
    @(posedge core_clk_i);
    power_fail_int_en_i <= 1'b1;
    power_fail_route_i <= 1'b1;
    fail_req <= 1'b1;
    wait_sig(0, 1'b1, n);
    chk_in(n, 600, 1270, "debounce");
    wait_sig(1, 1'b1, n);
    chk_in(n, 0, 2, "lock without delay");
    settle(2);
    chk({main_status_o[ST_PF_BIT], multi_function_output_o, interrupt_output_o}, 3'b110,
        "power-fail interrupt");
    wr_status(8'hFF);
    wr_cmp(3'h5, 8'hEE);
    settle(3);
    chk({15'h0, main_status_o[ST_PF_BIT]}, 16'h0001, "flag not clearable");
    @(posedge core_clk_i);
    power_fail_int_en_i <= 1'b0;
    settle(3);
    chk({14'h0, multi_function_output_o, bus_locked_o}, 16'h0001, "masked, still locked");
    set_fail(1'b0);
    wait_sig(1, 1'b0, n);
    chk_in(n, 600, 1270, "unlock debounce");
    rd_cmp(3'h5, 8'hA5);
    @(posedge core_clk_i);
    delay_en_i <= 1'b1;
    fail_req <= 1'b1;
    wait_sig(0, 1'b1, n);
    settle(200);
    chk({14'h0, bus_locked_o, interrupt_output_o | multi_function_output_o}, 16'h0000,
        "grace window open");
    @(posedge core_clk_i);
    delay_en_i <= 1'b0;
    settle(3);
    chk({15'h0, bus_locked_o}, 16'h0001, "early lock");
    set_fail(1'b0);
    wait_sig(1, 1'b0, n);
    @(posedge core_clk_i);
    delay_en_i <= 1'b1;
    fail_req <= 1'b1;
    wait_sig(0, 1'b1, n);
    wait_sig(1, 1'b1, n);
    chk_in(n, 9560, 9660, "full grace delay");
    set_fail(1'b0);
    wait_sig(1, 1'b0, n);
    @(posedge core_clk_i);
    chip_select_i <= 1'b1;
    read_strobe_i <= 1'b1;
    fail_req <= 1'b1;
    wait_sig(0, 1'b1, n);
    wait_sig(1, 1'b1, n);
    chk_in(n, 600, 700, "held access forces lock");
    @(posedge core_clk_i);
    chip_select_i <= 1'b0;
    read_strobe_i <= 1'b0;
    fail_req <= 1'b0;
    wait_sig(1, 1'b0, n);
    conclude();
  end
endmodule : alarm_periodic_powerfail_irq_bench

// File: bench/supply_monitor_model.sv
// Behavioural supply monitor that drives the active-low power-fail line.
`timescale 1ns/10ps
module supply_monitor_model (
  input  wire logic core_clk_i,
  input  wire logic fail_req_i,
  output logic      power_fail_input_n_o
);
  // The model steps the line on the core clock, 7 ns after each rising edge, not free-running like a board comparator.
  // The skew keeps its edges well away from the sampling edge.
  initial power_fail_input_n_o = 1'b1;
  always @(posedge core_clk_i) begin
    power_fail_input_n_o <= #7 ~fail_req_i;
  end
endmodule : supply_monitor_model

// File: design/alarm_periodic_powerfail_irq.sv
// Alarm, periodic and power-fail interrupt logic with host bus lock-out.
// What this block does
// - Alarm flag sets when enabled bytes all match; interrupt needs alarm enable.
// - Six compare bytes, each enabled by its own bit.
// - A disabled compare byte always counts as matching.
// - Host writing one to status D3 clears the alarm flag.
// - Disabled compare bytes serve as plain storage without affecting the alarm.
// - Six periodic flags set by ticks regardless of interrupt enables.
// - Any read or write of the periodic flags clears them all.
// - Enabled periodic event sets periodic status flag and raises interrupt.
// - Periodic route bit steers periodic interrupt to interrupt or multi-function output.
// - Writing one to periodic status flag clears flag and interrupt.
// - Pending periodic flag stays set after enables clear, until host clears.
// - Power-fail flag tracks internal power-fail, not host clearable.
// - Power-fail interrupt needs its enable, follows its route bit.
// - Low power-fail input debounced 30 to 63 us before failing declared.
// - Without delay, bus lock-out happens inside the debounce window.
// - With delay enabled, bus stays usable 480 us after detection.
// - An access held over 30 us after power fail forces lock-out.
// - Clearing delay enable during the window locks out at once.
// - While locked, chip select, strobes and data are ignored; compare byte reads still follow the address.
// - Two mode bits keep timers and interrupts working after power fail.
// - Stay locked while input low; unlock after another debounce once high.
// - Masked power-fail interrupt still performs lock-out, without interrupt.
// - Status D0 shows whether either interrupt output is active.
`timescale 1ns/10ps
module alarm_periodic_powerfail_irq
  import irq_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      power_fail_input_n_i,
  input  wire logic [NUM_CMP*BYTE_W-1:0] clock_counters_i,
  input  wire logic [NUM_PER-1:0]        periodic_ticks_i,
  input  wire logic [NUM_CMP-1:0]        alarm_cmp_en_i,
  input  wire logic                      alarm_int_en_i,
  input  wire logic [NUM_PER-1:0]        periodic_en_i,
  input  wire logic                      periodic_route_i,
  input  wire logic                      power_fail_int_en_i,
  input  wire logic                      power_fail_route_i,
  input  wire logic                      delay_en_i,
  input  wire logic                      timer_pf_run_i,
  input  wire logic                      int_pf_run_i,
  input  wire logic                      chip_select_i,
  input  wire logic                      read_strobe_i,
  input  wire logic                      write_strobe_i,
  input  wire logic                      status_wr_i,
  input  wire logic [STAT_W-1:0]         status_wr_data_i,
  input  wire logic                      periodic_access_i,
  input  wire logic                      cmp_wr_i,
  input  wire logic [CMP_AW-1:0]         cmp_addr_i,
  input  wire logic [BYTE_W-1:0]         cmp_wr_data_i,
  output logic      [BYTE_W-1:0]         cmp_rd_data_o,
  output logic      [STAT_W-1:0]         main_status_o,
  output logic      [NUM_PER-1:0]        periodic_flags_o,
  output logic                           interrupt_output_o,
  output logic                           multi_function_output_o,
  output logic                           bus_locked_o,
  output logic                           timers_enabled_o,
  output logic                           power_failing_o
);
  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [2:0] {
    PF_OK      = 3'h0,
    PF_DEB_LOW = 3'h1,
    PF_DELAY   = 3'h2,
    PF_LOCKED  = 3'h3,
    PF_DEB_HI  = 3'h4
  } pf_state_t;

  function automatic logic bytes_match(input logic [NUM_CMP*BYTE_W-1:0] a,
                                       input logic [NUM_CMP*BYTE_W-1:0] b,
                                       input logic [NUM_CMP-1:0]        en);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (en[i] && (a[i*BYTE_W +: BYTE_W] != b[i*BYTE_W +: BYTE_W])) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : bytes_match

  logic                      pf_s1_r, pf_s2_r, pf_s3_r;
  logic                      pf_low_r;
  logic                      pf_low_nxt;
  pf_state_t                 st_r, st_nxt;
  logic [CNT_W-1:0]          cnt_r, cnt_nxt;
  logic [CNT_W-1:0]          safe_r, safe_nxt;
  logic                      safe_arm_r, safe_arm_nxt;
  logic [TICK_W-1:0]         pre_r, pre_nxt;
  logic                      us_tick;
  logic                      alarm_r, alarm_nxt;
  logic                      match_r, match_nxt;
  logic                      per_int_r, per_int_nxt;
  logic [NUM_PER-1:0]        pflags_r, pflags_nxt;
  logic                      lock_r, lock_nxt;
  logic                      failing_r, failing_nxt;
  logic                      interrupt_output_r, interrupt_output_nxt;
  logic                      mfo_r, mfo_nxt;
  logic                      ints_live;
  logic                      pf_int;
  logic [NUM_CMP*BYTE_W-1:0] cmp_all;
  // Helper for the lock-out bound: cycles spent low with no delay and no lock yet.
  localparam logic [10:0]    LOCK_WAIT_MAX = 11'h514;
  logic [10:0]               lock_wait_r, lock_wait_nxt;

  always_comb begin
    lock_wait_nxt = lock_wait_r;
    if (!pf_low_r || delay_en_i || lock_r) begin
      lock_wait_nxt = '0;
    end else if (lock_wait_r != LOCK_WAIT_MAX) begin
      lock_wait_nxt = lock_wait_r + 11'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lock_wait_r <= '0;
    end else begin
      lock_wait_r <= lock_wait_nxt;
    end
  end

  // ****************************************
  // Compare byte storage
  // ****************************************
  // plain storage: the bytes are writable unless locked, the enable only gates matching.
  cmp_ram u_cmp_ram (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_en_i    (cmp_wr_i && !lock_r),
    .wr_addr_i  (cmp_addr_i),
    .wr_data_i  (cmp_wr_data_i),
    .rd_addr_i  (cmp_addr_i),
    .rd_data_o  (cmp_rd_data_o),
    .all_o      (cmp_all)
  );

  // ****************************************
  // Power-fail input synchroniser and tick
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pf_s1_r <= 1'b1;
      pf_s2_r <= 1'b1;
      pf_s3_r <= 1'b1;
    end else begin
      pf_s1_r <= power_fail_input_n_i;
      pf_s2_r <= pf_s1_r;
      pf_s3_r <= pf_s2_r;
    end
  end

  // microsecond tick: the prescaler runs freely from the core clock.
  always_comb begin
    pre_nxt = (pre_r == TICK_LAST) ? TICK_ZERO : pre_r + 1'b1;
    us_tick = (pre_r == TICK_LAST);
    pf_low_nxt = pf_low_r;
    if (pf_s2_r == pf_s3_r) begin
      pf_low_nxt = !pf_s3_r;
    end
  end

  // ****************************************
  // Power-fail and lock-out state machine
  // ****************************************
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    safe_nxt     = safe_r;
    safe_arm_nxt = safe_arm_r;
    unique case (st_r)
      PF_OK: begin
        cnt_nxt = CNT_ZERO;
        if (pf_low_r) begin
          st_nxt = PF_DEB_LOW;
        end
      end
      // debounce low: counting whole ticks keeps the wait inside the window.
      PF_DEB_LOW: begin
        if (!pf_low_r) begin
          st_nxt = PF_OK;
        end else if (us_tick) begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == DEB_CNT) begin
            cnt_nxt      = CNT_ZERO;
            safe_nxt     = CNT_ZERO;
            safe_arm_nxt = chip_select_i;
            // immediate lock when no delay is requested.
            st_nxt = delay_en_i ? PF_DELAY : PF_LOCKED;
          end
        end
      end
      PF_DELAY: begin
        if (us_tick) begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
        if (us_tick && safe_arm_r) begin
          safe_nxt = safe_r + CNT_ONE;
        end
        if (!(chip_select_i && (read_strobe_i || write_strobe_i))) begin
          safe_arm_nxt = 1'b0;
        end
        // early lock when software drops the delay enable.
        if (!delay_en_i) begin
          st_nxt = PF_LOCKED;
        // lock after the grace delay has run out.
        end else if (cnt_r >= DELAY_CNT) begin
          st_nxt = PF_LOCKED;
        // safety lock for an access stuck across power fail.
        end else if (safe_arm_r && (safe_r >= SAFE_CNT)) begin
          st_nxt = PF_LOCKED;
        end
      end
      // hold the lock while the input is low.
      PF_LOCKED: begin
        cnt_nxt = CNT_ZERO;
        if (!pf_low_r) begin
          st_nxt = PF_DEB_HI;
        end
      end
      // second debounce before the bus is released.
      PF_DEB_HI: begin
        if (pf_low_r) begin
          st_nxt = PF_LOCKED;
        end else if (us_tick) begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (cnt_r == DEB_CNT) begin
            st_nxt = PF_OK;
          end
        end
      end
      default: begin
        st_nxt = PF_LOCKED;
      end
    endcase
    failing_nxt = (st_nxt == PF_DELAY) || (st_nxt == PF_LOCKED) || (st_nxt == PF_DEB_HI);
    // lock-out does not depend on the interrupt enable.
    lock_nxt = (st_nxt == PF_LOCKED) || (st_nxt == PF_DEB_HI);
  end

  // ****************************************
  // Flags and outputs
  // ****************************************
  // interrupts may be told to stop once power has failed.
  assign ints_live = !failing_r || int_pf_run_i;
  // power-fail interrupt gated by its enable.
  assign pf_int    = failing_r && power_fail_int_en_i && ints_live;

  always_comb begin
    // enabled bytes only; the flag sets on the edge into a match.
    match_nxt = bytes_match(cmp_all, clock_counters_i, alarm_cmp_en_i);
    alarm_nxt = alarm_r;
    // clear by writing one; a new match in the same cycle wins.
    if (status_wr_i && !lock_r && status_wr_data_i[ST_ALM_BIT]) begin
      alarm_nxt = 1'b0;
    end
    if (match_nxt && !match_r) begin
      alarm_nxt = 1'b1;
    end
    // any access clears the periodic flags; new ticks still win.
    pflags_nxt = pflags_r;
    if (periodic_access_i && !lock_r) begin
      pflags_nxt = '0;
    end
    // ticks set flags irrespective of enables.
    pflags_nxt = pflags_nxt | periodic_ticks_i;
    per_int_nxt = per_int_r;
    if (status_wr_i && !lock_r && status_wr_data_i[ST_PER_BIT]) begin
      per_int_nxt = 1'b0;
    end
    // set on enabled ticks, stays set until written off.
    if ((periodic_ticks_i & periodic_en_i) != '0) begin
      per_int_nxt = 1'b1;
    end
    // steering of periodic and power-fail interrupts.
    interrupt_output_nxt = ints_live && ((alarm_r && alarm_int_en_i)
             || (per_int_r && !periodic_route_i)) || (pf_int && !power_fail_route_i);
    mfo_nxt  = (ints_live && per_int_r && periodic_route_i) || (pf_int && power_fail_route_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pf_low_r   <= 1'b0;
      pre_r      <= TICK_ZERO;
      st_r       <= PF_OK;
      cnt_r      <= CNT_ZERO;
      safe_r     <= CNT_ZERO;
      safe_arm_r <= 1'b0;
      failing_r  <= 1'b0;
      lock_r     <= 1'b0;
      match_r    <= 1'b0;
      alarm_r    <= 1'b0;
      pflags_r   <= '0;
      per_int_r  <= 1'b0;
      interrupt_output_r     <= 1'b0;
      mfo_r      <= 1'b0;
    end else begin
      pf_low_r   <= pf_low_nxt;
      pre_r      <= pre_nxt;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      safe_r     <= safe_nxt;
      safe_arm_r <= safe_arm_nxt;
      failing_r  <= failing_nxt;
      lock_r     <= lock_nxt;
      match_r    <= match_nxt;
      alarm_r    <= alarm_nxt;
      pflags_r   <= pflags_nxt;
      per_int_r  <= per_int_nxt;
      interrupt_output_r     <= interrupt_output_nxt;
      mfo_r      <= mfo_nxt;
    end
  end

  // power-fail flag follows the failing state; D0 mirrors both pins.
  // all host writes above are gated by the lock so pins are ignored.
  always_comb begin
    main_status_o             = '0;
    main_status_o[ST_INT_BIT] = interrupt_output_r || mfo_r;
    main_status_o[ST_PF_BIT]  = failing_r;
    main_status_o[ST_PER_BIT] = per_int_r;
    main_status_o[ST_ALM_BIT] = alarm_r;
  end
  assign periodic_flags_o        = pflags_r;
  assign interrupt_output_o      = interrupt_output_r;
  assign multi_function_output_o = mfo_r;
  assign bus_locked_o            = lock_r;
  assign power_failing_o         = failing_r;
  assign timers_enabled_o        = !failing_r || timer_pf_run_i;

  // ****************************************
  // Assertions
  // ****************************************
  a_alarm_clear_wr: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (status_wr_i && !lock_r && status_wr_data_i[ST_ALM_BIT] && !(match_nxt && !match_r))
    |=> !alarm_r) else $error("alarm flag not cleared");
  a_alarm_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (match_nxt && !match_r) |=> alarm_r) else $error("alarm flag not set");
  a_per_sticky: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (per_int_r && !(status_wr_i && !lock_r && status_wr_data_i[ST_PER_BIT]))
    |=> per_int_r) else $error("periodic flag dropped");
  a_per_set: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ((periodic_ticks_i & periodic_en_i) != '0) |=> per_int_r) else $error("periodic not set");
  a_pflag_tick: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (periodic_ticks_i[0]) |=> pflags_r[0]) else $error("periodic flag missed tick");
  a_no_early_lock: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(pf_low_r) |-> !failing_r [*8]) else $error("failing declared too soon");
  a_lock_bound: assert property (@(posedge core_clk_i) disable iff (reset_i)
    lock_wait_r != LOCK_WAIT_MAX) else $error("lock-out late");
  a_early_lock: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (st_r == PF_DELAY && !delay_en_i) |=> lock_r) else $error("no early lock");
  a_pf_mask: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!power_fail_int_en_i && !alarm_r && !per_int_r) |=> !interrupt_output_r && !mfo_r)
    else $error("masked power-fail interrupt seen");
  a_status_d0: assert property (@(posedge core_clk_i) disable iff (reset_i)
    main_status_o[ST_INT_BIT] == (interrupt_output_r || mfo_r)) else $error("D0 mismatch");
  c_alarm_fire: cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(alarm_r));
  c_lock: cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(lock_r));
  c_delay: cover property (@(posedge core_clk_i) disable iff (reset_i) st_r == PF_DELAY);
  c_unlock: cover property (@(posedge core_clk_i) disable iff (reset_i) $fell(lock_r));
endmodule : alarm_periodic_powerfail_irq

// File: design/cmp_ram.sv
// Small register memory holding the alarm compare bytes.
`timescale 1ns/10ps
module cmp_ram
  import irq_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      wr_en_i,
  input  wire logic [CMP_AW-1:0]         wr_addr_i,
  input  wire logic [BYTE_W-1:0]         wr_data_i,
  input  wire logic [CMP_AW-1:0]         rd_addr_i,
  output logic      [BYTE_W-1:0]         rd_data_o,
  output logic      [NUM_CMP*BYTE_W-1:0] all_o
);
  logic [BYTE_W-1:0] mem_r   [NUM_CMP];
  logic [BYTE_W-1:0] mem_nxt [NUM_CMP];
  logic [BYTE_W-1:0] rd_r;
  logic [BYTE_W-1:0] rd_nxt;

  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      mem_nxt[i] = mem_r[i];
      if (wr_en_i && (wr_addr_i == CMP_AW'(i))) begin
        mem_nxt[i] = wr_data_i;
      end
    end
    rd_nxt = BYTE_ZERO;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (rd_addr_i == CMP_AW'(i)) begin
        rd_nxt = mem_r[i];
      end
    end
    for (int i = 0; i < NUM_CMP; i++) begin
      all_o[i*BYTE_W +: BYTE_W] = mem_r[i];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        mem_r[i] <= BYTE_ZERO;
      end
      rd_r <= BYTE_ZERO;
    end else begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign rd_data_o = rd_r;
endmodule : cmp_ram

// File: include/irq_pkg.sv
// Package with constants for the alarm, periodic and power-fail interrupt block.
package irq_pkg;
  // ****************************************
  // Sizes and bit positions
  // ****************************************
  localparam int unsigned NUM_CMP     = 6;
  localparam int unsigned NUM_PER     = 6;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned CMP_AW      = 3;
  localparam int unsigned STAT_W      = 8;
  localparam int unsigned ST_INT_BIT  = 0;
  localparam int unsigned ST_PF_BIT   = 1;
  localparam int unsigned ST_PER_BIT  = 2;
  localparam int unsigned ST_ALM_BIT  = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ     = 20;
  localparam int unsigned TICK_US     = 1;
  localparam int unsigned TICK_CYC    = TICK_US * CLK_MHZ;
  localparam int unsigned DEB_MIN_US  = 30;
  localparam int unsigned DEB_MAX_US  = 63;
  localparam int unsigned DEB_US      = 31;
  localparam int unsigned SAFE_US     = 30;
  localparam int unsigned DELAY_US    = 480;
  localparam int unsigned CNT_W       = 10;
  localparam int unsigned TICK_W      = 5;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 10'h000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 10'h001;
  localparam logic [TICK_W-1:0] TICK_ZERO = 5'h00;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [CNT_W-1:0]  DEB_CNT   = CNT_W'(DEB_US);
  localparam logic [CNT_W-1:0]  SAFE_CNT  = CNT_W'(SAFE_US + 1);
  localparam logic [CNT_W-1:0]  DELAY_CNT = CNT_W'(DELAY_US);
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage : irq_pkg
